/* File: drs_pkg.sv */
// Shared constants and types for the disk read and step engine
package drs_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_PARAM = 8'h04;
  localparam logic [7:0] OFF_MODE = 8'h08;
  localparam logic [7:0] OFF_TIMING = 8'h0c;
  localparam logic [7:0] OFF_REL = 8'h10;
  localparam logic [7:0] OFF_FIFO = 8'h14;
  localparam logic [7:0] OFF_MSR = 8'h18;
  localparam logic [7:0] OFF_RES0 = 8'h1c;
  localparam logic [7:0] OFF_RES1 = 8'h20;
  localparam logic [7:0] OFF_SENSE = 8'h24;
  localparam logic [7:0] OFF_PTR = 8'h28;
  // Values after reset
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [31:0] TIMING_RST = 32'h03e8_0bb8;
  localparam logic [7:0] REL_RST = 8'h00;
  // Mode bit positions
  localparam int MODE_XRECAL = 0;
  localparam int MODE_XTRK = 1;
  // Main status bit positions
  localparam int MSR_EXEC = 4;
  localparam int MSR_RES = 5;
  // Status one and two bit positions
  localparam int ST1_EOT = 7;
  localparam int ST1_CE = 5;
  localparam int ST1_ND = 2;
  localparam int ST1_MA = 0;
  localparam int ST2_CM = 6;
  localparam int ST2_CD = 5;
  // Status zero codes
  localparam logic [1:0] IC_NORM = 2'h0;
  localparam logic [1:0] IC_ABN = 2'h1;
  localparam logic [2:0] SEEK_NORM = 3'h1;
  localparam logic [2:0] SEEK_ABN = 3'h3;
  localparam logic [7:0] ST0_INVALID = 8'h80;
  // Recalibrate step maxima
  localparam logic [11:0] RECAL_STD = 12'd85;
  localparam logic [11:0] RECAL_R = 12'd255;
  localparam logic [11:0] RECAL_E = 12'd3925;
  localparam logic [11:0] RECAL_RE = 12'd4095;
  // Track pointer arithmetic wraps modulo 255
  localparam logic [7:0] TRK_TOP = 8'hfe;
  localparam logic [7:0] SECT_FIRST = 8'h01;
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int US_NS = 1000;
  localparam int US_CYC = (US_NS * CLK_MHZ) / 1000;
  localparam int STEP_PW_NS = 1000;
  localparam int STEP_PW_CYC = (STEP_PW_NS * CLK_MHZ + 999) / 1000;
  // Command codes
  typedef enum logic [3:0] {
    OP_READ = 4'h0,
    OP_READ_DEL = 4'h1,
    OP_READ_ID = 4'h2,
    OP_READ_TRK = 4'h3,
    OP_RECAL = 4'h4,
    OP_REL_SEEK = 4'h5
  } drs_op_e;
  // Command register layout
  typedef struct packed {
    logic [21:0] rsv;
    logic dir;
    logic head;
    logic multi_track_bit;
    logic skip_bit;
    logic [1:0] drive;
    logic [3:0] op;
  } drs_cmd_t;
  // Address field identification bytes
  typedef struct packed {
    logic [7:0] track;
    logic [7:0] head;
    logic [7:0] sector;
    logic [7:0] size;
  } drs_id_t;
  // Parameter register layout
  typedef struct packed {
    logic [7:0] size;
    logic [7:0] end_of_track_sector;
    logic [7:0] sector;
    logic [7:0] track;
  } drs_par_t;
endpackage

/* File: drs_engine.sv */
// Read, identify, track read, recalibrate and relative seek engine
//
// The Avalon-MM interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module drs_engine
  import drs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Drive pins, asynchronous
  input wire logic index_pin,
  input wire logic track_zero_input,
  output logic step_out,
  output logic dir_out,
  output logic int_out,
  // Data separator, same clock
  input wire logic af_valid,
  input wire drs_id_t af_id,
  input wire logic af_crc_ok,
  input wire logic dm_valid,
  input wire logic dm_deleted,
  input wire logic df_end,
  input wire logic df_crc_ok,
  input wire logic tc_in,
  output logic sep_on,
  output logic xfer_en
);

  // Engine states
  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_MOTOR = 7'h02,
    S_INDEX = 7'h04,
    S_SEARCH = 7'h08,
    S_MARK = 7'h10,
    S_READ = 7'h20,
    S_RESULT = 7'h40
  } drs_state_t;

  // Bus registers
  logic wait_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  drs_cmd_t cmd_ff;
  drs_par_t par_ff;
  logic [1:0] mode_ff;
  logic [31:0] timing_ff;
  logic [7:0] rel_ff;
  // Pin synchronisers
  logic idx_s1_ff, idx_s2_ff, idx_s3_ff;
  logic tz_s1_ff, tz_s2_ff;
  // Microsecond prescaler
  logic [15:0] us_cnt_ff;
  logic us_tick_ff;
  // Engine state
  drs_state_t st_ff;
  logic [15:0] mot_cnt_ff;
  logic idx1_ff;
  logic am_seen_ff;
  logic cur_head_ff;
  logic [7:0] cur_sec_ff;
  logic [7:0] st1_ff, st2_ff;
  logic ab_ff;
  logic stop_ff;
  logic tc_ff;
  drs_id_t res_ff;
  logic exec_int_ff;
  logic stp_go_ff;
  logic sep_ff, xfer_ff, int_ff;
  // Stepper state
  logic stp_on_ff;
  logic stp_recal_ff;
  logic stp_in_ff;
  logic [1:0] stp_drv_ff;
  logic [11:0] left_ff;
  logic [15:0] tmr_ff;
  logic [15:0] pw_ff;
  logic step_ff, dir_ff;
  logic [3:0] busy_ff;
  logic [7:0] ptr_ff [4];
  logic seek_int_ff;
  logic [7:0] seek_st0_ff;

  // Bus decode
  logic acc, rd_res0, rd_res1, rd_sense, wr_fifo, launch;
  drs_cmd_t wcmd;
  assign acc = (avs_read | avs_write) & ~wait_ff;
  assign rd_res0 = acc & avs_read & (avs_address == OFF_RES0);
  assign rd_res1 = acc & avs_read & (avs_address == OFF_RES1);
  assign rd_sense = acc & avs_read & (avs_address == OFF_SENSE);
  assign wr_fifo = acc & avs_write & (avs_address == OFF_FIFO);
  assign wcmd = drs_cmd_t'(avs_writedata);
  // New command only when engine, stepper and drives are quiet
  assign launch = acc & avs_write & (avs_address == OFF_CMD) & (st_ff == S_IDLE)
    & ~stp_on_ff & ~(|busy_ff) & (wcmd.op <= OP_REL_SEEK);

  // Command decode helpers
  logic is_trk, is_id, is_step, at_eot, id_match, wanted, idx_rise, tz;
  drs_id_t cur_id, adv_id;
  logic [7:0] head_byte;
  assign is_trk = cmd_ff.op == OP_READ_TRK;
  assign is_id = cmd_ff.op == OP_READ_ID;
  assign is_step = (cmd_ff.op == OP_RECAL) | (cmd_ff.op == OP_REL_SEEK);
  assign at_eot = cur_sec_ff == par_ff.end_of_track_sector;
  assign head_byte = {7'h00, cur_head_ff};
  assign idx_rise = idx_s2_ff & ~idx_s3_ff;
  assign tz = tz_s2_ff;
  // Wanted mark depends on the command
  assign wanted = ((cmd_ff.op == OP_READ_DEL) == dm_deleted);
  // Track read leaves the sector out of the compare
  assign id_match = (af_id.track == par_ff.track) && (af_id.head == head_byte)
    && (af_id.size == par_ff.size)
    && (is_trk || (af_id.sector == cur_sec_ff));
  assign cur_id = '{par_ff.track, head_byte, cur_sec_ff, par_ff.size};
  // Result after a clean end
  always_comb
  begin
    adv_id = cur_id;
    if (at_eot)
    begin
      adv_id.track = par_ff.track + 8'h01;
      adv_id.sector = SECT_FIRST;
    end
    else
      adv_id.sector = cur_sec_ff + 8'h01;
    if (cmd_ff.multi_track_bit)
      adv_id.head = at_eot ? 8'h00 : head_byte;
    else
      adv_id.head = {7'h00, cmd_ff.head};
  end

  // Advance to next sector after a read or a skip
  logic do_adv;
  assign do_adv = ((st_ff == S_MARK) & dm_valid & ~is_trk & ~wanted & cmd_ff.skip_bit)
    | ((st_ff == S_READ) & df_end & (df_crc_ok | is_trk) & ~(stop_ff | tc_ff | tc_in));

  // Two-flop synchronisers for drive pins
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      idx_s1_ff <= 1'b0;
      idx_s2_ff <= 1'b0;
      idx_s3_ff <= 1'b0;
      tz_s1_ff <= 1'b0;
      tz_s2_ff <= 1'b0;
    end
    else
    begin
      idx_s1_ff <= index_pin;
      idx_s2_ff <= idx_s1_ff;
      idx_s3_ff <= idx_s2_ff;
      tz_s1_ff <= track_zero_input;
      tz_s2_ff <= tz_s1_ff;
    end
  end

  // Microsecond tick for motor and step timers
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      us_cnt_ff <= 16'h0000;
      us_tick_ff <= 1'b0;
    end
    else
    begin
      us_tick_ff <= us_cnt_ff == 16'(US_CYC - 1);
      us_cnt_ff <= (us_cnt_ff == 16'(US_CYC - 1)) ? 16'h0000 : us_cnt_ff + 16'h0001;
    end
  end

  // Bus handshake: one wait cycle then accept
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wait_ff <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end
    else
    begin
      wait_ff <= ~((avs_read | avs_write) & wait_ff);
      if (avs_read & wait_ff)
        rdata_ff <= nxt_rdata;
    end
  end

  // Writable configuration registers
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      par_ff <= '0;
      mode_ff <= MODE_RST;
      timing_ff <= TIMING_RST;
      rel_ff <= REL_RST;
    end
    else if (acc & avs_write & (st_ff == S_IDLE))
    begin
      if (avs_address == OFF_PARAM)
        par_ff <= drs_par_t'(avs_writedata);
      else if (avs_address == OFF_MODE)
        mode_ff <= avs_writedata[1:0];
      else if (avs_address == OFF_TIMING)
        timing_ff <= avs_writedata;
      else if (avs_address == OFF_REL)
        rel_ff <= avs_writedata[7:0];
    end
  end

  // Read mux
  always_comb
  begin
    nxt_rdata = 32'h0000_0000;
    if (avs_address == OFF_CMD)
      nxt_rdata = cmd_ff;
    else if (avs_address == OFF_PARAM)
      nxt_rdata = par_ff;
    else if (avs_address == OFF_MODE)
      nxt_rdata = {30'h0, mode_ff};
    else if (avs_address == OFF_TIMING)
      nxt_rdata = timing_ff;
    else if (avs_address == OFF_REL)
      nxt_rdata = {24'h0, rel_ff};
    else if (avs_address == OFF_MSR)
    begin
      nxt_rdata[3:0] = busy_ff;
      nxt_rdata[MSR_EXEC] = ~(st_ff inside {S_IDLE, S_RESULT});
      nxt_rdata[MSR_RES] = st_ff == S_RESULT;
    end
    else if (avs_address == OFF_RES0)
      nxt_rdata = {8'h00, st2_ff, st1_ff, ab_ff ? IC_ABN : IC_NORM, 3'h0,
        cur_head_ff, cmd_ff.drive};
    else if (avs_address == OFF_RES1)
      nxt_rdata = res_ff;
    else if (avs_address == OFF_SENSE)
      // Sense without a pending seek answers as invalid
      nxt_rdata = seek_int_ff ? {16'h0, ptr_ff[stp_drv_ff], seek_st0_ff}
        : {24'h0, ST0_INVALID};
    else if (avs_address == OFF_PTR)
      nxt_rdata = {ptr_ff[3], ptr_ff[2], ptr_ff[1], ptr_ff[0]};
  end

  // Command engine
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_ff <= S_IDLE;
      cmd_ff <= '0;
      mot_cnt_ff <= 16'h0000;
      idx1_ff <= 1'b0;
      am_seen_ff <= 1'b0;
      cur_head_ff <= 1'b0;
      cur_sec_ff <= 8'h00;
      st1_ff <= 8'h00;
      st2_ff <= 8'h00;
      ab_ff <= 1'b0;
      stop_ff <= 1'b0;
      tc_ff <= 1'b0;
      res_ff <= '0;
      exec_int_ff <= 1'b0;
      stp_go_ff <= 1'b0;
    end
    else
    begin
      stp_go_ff <= 1'b0;
      // Reading the first result clears; a new finish still wins
      if (rd_res0)
        exec_int_ff <= 1'b0;
      case (st_ff)
        S_IDLE:
          if (launch)
          begin
            cmd_ff <= wcmd;
            cur_head_ff <= wcmd.head;
            cur_sec_ff <= par_ff.sector;
            st1_ff <= 8'h00;
            st2_ff <= 8'h00;
            ab_ff <= 1'b0;
            stop_ff <= 1'b0;
            tc_ff <= 1'b0;
            idx1_ff <= 1'b0;
            am_seen_ff <= 1'b0;
            // Every command first waits the motor-on time
            mot_cnt_ff <= timing_ff[31:16];
            st_ff <= S_MOTOR;
          end
        S_MOTOR:
          if (mot_cnt_ff == 16'h0000)
          begin
            if (is_step)
            begin
              stp_go_ff <= 1'b1;
              st_ff <= S_IDLE;
            end
            else if (is_trk)
            begin
              cur_sec_ff <= SECT_FIRST;
              st_ff <= S_INDEX;
            end
            else
              st_ff <= S_SEARCH;
          end
          else if (us_tick_ff)
            mot_cnt_ff <= mot_cnt_ff - 16'h0001;
        S_INDEX:
          if (wr_fifo)
          begin
            ab_ff <= 1'b1;
            res_ff <= cur_id;
            exec_int_ff <= 1'b1;
            st_ff <= S_RESULT;
          end
          else if (idx_rise)
            st_ff <= S_SEARCH;
        S_SEARCH:
          if (wr_fifo)
          begin
            // Host byte ends a search, also a hung one
            ab_ff <= 1'b1;
            res_ff <= cur_id;
            exec_int_ff <= 1'b1;
            st_ff <= S_RESULT;
          end
          else if (af_valid)
          begin
            am_seen_ff <= 1'b1;
            if (is_id)
            begin
              // Found field goes straight to results
              res_ff <= af_id;
              ab_ff <= ~af_crc_ok;
              st1_ff[ST1_CE] <= ~af_crc_ok;
              exec_int_ff <= 1'b1;
              st_ff <= S_RESULT;
            end
            else if (is_trk)
            begin
              // Errors flagged, sector read anyway
              if (!id_match)
                st1_ff[ST1_ND] <= 1'b1;
              if (!af_crc_ok)
                st1_ff[ST1_CE] <= 1'b1;
              st_ff <= S_MARK;
            end
            else if (!af_crc_ok)
            begin
              st1_ff[ST1_CE] <= 1'b1;
              ab_ff <= 1'b1;
              res_ff <= cur_id;
              exec_int_ff <= 1'b1;
              st_ff <= S_RESULT;
            end
            else if (id_match)
              st_ff <= S_MARK;
          end
          else if (idx_rise)
          begin
            if (idx1_ff)
            begin
              // Second index without success
              if (am_seen_ff)
                st1_ff[ST1_ND] <= 1'b1;
              else
                st1_ff[ST1_MA] <= 1'b1;
              ab_ff <= 1'b1;
              res_ff <= cur_id;
              exec_int_ff <= 1'b1;
              st_ff <= S_RESULT;
            end
            else
              idx1_ff <= 1'b1;
          end
        S_MARK:
          if (dm_valid)
          begin
            if (is_trk || wanted)
              st_ff <= S_READ;
            else
            begin
              st2_ff[ST2_CM] <= 1'b1;
              if (!cmd_ff.skip_bit)
              begin
                stop_ff <= 1'b1;
                st_ff <= S_READ;
              end
            end
          end
        S_READ:
        begin
          if (tc_in)
            tc_ff <= 1'b1;
          if (df_end)
          begin
            if (!df_crc_ok)
            begin
              st1_ff[ST1_CE] <= 1'b1;
              st2_ff[ST2_CD] <= 1'b1;
            end
            if (!df_crc_ok && !is_trk)
            begin
              ab_ff <= 1'b1;
              res_ff <= cur_id;
              exec_int_ff <= 1'b1;
              st_ff <= S_RESULT;
            end
            else if (stop_ff || tc_ff || tc_in)
            begin
              res_ff <= adv_id;
              exec_int_ff <= 1'b1;
              st_ff <= S_RESULT;
            end
          end
        end
        S_RESULT:
          if (rd_res1)
            st_ff <= S_IDLE;
        default:
          st_ff <= S_IDLE;
      endcase
      // Next sector, other side, or end of track
      if (do_adv)
      begin
        idx1_ff <= 1'b0;
        am_seen_ff <= 1'b0;
        if (!at_eot)
        begin
          cur_sec_ff <= cur_sec_ff + 8'h01;
          st_ff <= S_SEARCH;
        end
        else if (cmd_ff.multi_track_bit && !cur_head_ff && !is_trk)
        begin
          cur_head_ff <= 1'b1;
          cur_sec_ff <= SECT_FIRST;
          st_ff <= S_SEARCH;
        end
        else
        begin
          st1_ff[ST1_EOT] <= 1'b1;
          ab_ff <= 1'b1;
          res_ff <= adv_id;
          exec_int_ff <= 1'b1;
          st_ff <= S_RESULT;
        end
      end
    end
  end

  // Recalibrate step limit
  logic [11:0] recal_max;
  always_comb
  begin
    case ({mode_ff[MODE_XTRK], mode_ff[MODE_XRECAL]})
      2'b01: recal_max = RECAL_R;
      2'b10: recal_max = RECAL_E;
      2'b11: recal_max = RECAL_RE;
      default: recal_max = RECAL_STD;
    endcase
  end

  // Stepper, run in the idle phase
  logic stp_stop;
  assign stp_stop = (left_ff == 12'h000) | (tz & ~stp_in_ff);
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      stp_on_ff <= 1'b0;
      stp_recal_ff <= 1'b0;
      stp_in_ff <= 1'b0;
      stp_drv_ff <= 2'h0;
      left_ff <= 12'h000;
      tmr_ff <= 16'h0000;
      busy_ff <= 4'h0;
      seek_st0_ff <= 8'h00;
      for (int i = 0; i < 4; i++)
        ptr_ff[i] <= 8'h00;
    end
    else if (launch && ((wcmd.op == OP_RECAL) || (wcmd.op == OP_REL_SEEK)))
    begin
      busy_ff[wcmd.drive] <= 1'b1;
      stp_drv_ff <= wcmd.drive;
      if (wcmd.op == OP_RECAL)
        ptr_ff[wcmd.drive] <= 8'h00;
    end
    else if (stp_go_ff)
    begin
      stp_on_ff <= 1'b1;
      stp_recal_ff <= cmd_ff.op == OP_RECAL;
      stp_in_ff <= (cmd_ff.op == OP_REL_SEEK) & cmd_ff.dir;
      left_ff <= (cmd_ff.op == OP_RECAL) ? recal_max : {4'h0, rel_ff};
      tmr_ff <= 16'h0000;
    end
    else if (stp_on_ff)
    begin
      if (tmr_ff != 16'h0000)
      begin
        if (us_tick_ff)
          tmr_ff <= tmr_ff - 16'h0001;
      end
      else if (stp_stop)
      begin
        // Done one step period after the last pulse
        stp_on_ff <= 1'b0;
        busy_ff[stp_drv_ff] <= 1'b0;
        seek_st0_ff <= {(stp_recal_ff && !tz) ? SEEK_ABN : SEEK_NORM,
          3'h0, stp_drv_ff};
      end
      else
      begin
        left_ff <= left_ff - 12'h001;
        tmr_ff <= (timing_ff[15:0] == 16'h0000) ? 16'h0001 : timing_ff[15:0];
        if (!stp_recal_ff)
        begin
          // Track count wraps modulo 255
          if (stp_in_ff)
            ptr_ff[stp_drv_ff] <= (ptr_ff[stp_drv_ff] == TRK_TOP) ? 8'h00
              : ptr_ff[stp_drv_ff] + 8'h01;
          else
            ptr_ff[stp_drv_ff] <= (ptr_ff[stp_drv_ff] == 8'h00) ? TRK_TOP
              : ptr_ff[stp_drv_ff] - 8'h01;
        end
      end
    end
  end

  // Step pulse width and direction
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pw_ff <= 16'h0000;
      step_ff <= 1'b0;
      dir_ff <= 1'b0;
    end
    else
    begin
      dir_ff <= stp_in_ff;
      if (stp_on_ff && (tmr_ff == 16'h0000) && !stp_stop)
      begin
        pw_ff <= 16'(STEP_PW_CYC);
        step_ff <= 1'b1;
      end
      else if (pw_ff != 16'h0000)
      begin
        pw_ff <= pw_ff - 16'h0001;
        step_ff <= pw_ff != 16'h0001;
      end
      else
        step_ff <= 1'b0;
    end
  end

  // Seek interrupt held until sense read; set beats clear
  logic seek_done;
  assign seek_done = stp_on_ff & (tmr_ff == 16'h0000) & stp_stop;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      seek_int_ff <= 1'b0;
    else
      seek_int_ff <= seek_done | (seek_int_ff & ~rd_sense);
  end

  // Registered side outputs
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sep_ff <= 1'b0;
      xfer_ff <= 1'b0;
      int_ff <= 1'b0;
    end
    else
    begin
      sep_ff <= st_ff inside {S_INDEX, S_SEARCH, S_MARK, S_READ};
      xfer_ff <= st_ff == S_READ;
      int_ff <= exec_int_ff | seek_int_ff;
    end
  end

  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign step_out = step_ff;
  assign dir_out = dir_ff;
  assign int_out = int_ff;
  assign sep_on = sep_ff;
  assign xfer_en = xfer_ff;

endmodule // drs_engine

`default_nettype wire

/* File: drs_sva.sv */
// Assertion checker for the disk read and step engine
`timescale 1ns/1ns
`default_nettype none
module drs_sva
  import drs_pkg::*;
(
  // Watched ports
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic track_zero_input,
  input wire logic step_out,
  input wire logic dir_out
);
  // Cycles the step pulse has been high
  int hi_ff;
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      hi_ff <= 0;
    else
      hi_ff <= step_out ? hi_ff + 1 : 0;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Head at track zero while set to step out
  sequence s_track_zero_input_out;
    (track_zero_input && !dir_out) [*6];
  endsequence
  wait_pulse_a: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
    else $error("bus answer late");
  wait_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer too long");
  wait_idle_a: assert property (!(avs_read || avs_write) |-> avs_waitrequest)
    else $error("answer with no request");
  rdata_hold_a: assert property (avs_waitrequest && $past(avs_waitrequest)
    |-> $stable(avs_readdata)) else $error("read data moved");
  unmap_zero_a: assert property (avs_read && !avs_waitrequest && avs_address == 8'h30
    |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  step_width_a: assert property ($fell(step_out) |-> hi_ff == STEP_PW_CYC)
    else $error("step width wrong");
  step_dir_a: assert property (step_out && $past(step_out) |-> $stable(dir_out))
    else $error("direction moved in pulse");
  step_track_zero_input_a: assert property (s_track_zero_input_out |-> !$rose(step_out))
    else $error("step out past track zero");
endmodule // drs_sva
bind drs_engine drs_sva u_drs_sva (.clk, .rstn, .avs_address, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .track_zero_input, .step_out, .dir_out);
`default_nettype wire

/* File: drs_drive.sv */
// Drive model: head position and track zero line
`timescale 1ns/1ns
`default_nettype none
module drs_drive #(parameter logic [7:0] START = 8'hc8)
(
  // Clock, reset and step pins
  input wire logic clk,
  input wire logic rstn,
  input wire logic step_out,
  input wire logic dir_out,
  // Head state
  output logic track_zero_input,
  output logic [7:0] pos
);
  logic st_q; // Previous step level
  // Head moves on each step rising edge, stops at zero
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      st_q <= 1'b0;
      pos <= START;
    end
    else
    begin
      st_q <= step_out;
      if (step_out && !st_q)
        pos <= dir_out ? pos + 8'h01 : (pos == 8'h00 ? pos : pos - 8'h01);
    end
  assign track_zero_input = (pos == 8'h00);
endmodule // drs_drive
`default_nettype wire

/* File: tb_top.sv */
// Testbench for the disk read and step engine
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import drs_pkg::*;
  logic clk, rstn, avs_read, avs_write, avs_waitrequest, index_pin, track_zero_input;
  logic step_out, dir_out, int_out, af_valid, af_crc_ok, sep_on, dir_seen;
  logic dm_valid, df_end, xfer_en;
  logic [7:0] avs_address, pos;
  logic [31:0] avs_writedata, avs_readdata, got;
  drs_id_t af_id;
  int n_fail, num_checks, n_step, gap, last, cyc;
  drs_engine u_drs_engine (.clk, .rstn, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .index_pin, .track_zero_input,
    .step_out, .dir_out, .int_out, .af_valid, .af_id, .af_crc_ok, .dm_valid,
    .dm_deleted(1'b0), .df_end, .df_crc_ok(1'b1), .tc_in(1'b0), .sep_on, .xfer_en);
  drs_drive u_drs_drive (.clk, .rstn, .step_out, .dir_out, .track_zero_input, .pos);
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // Step counter and interval meter
  always @(posedge clk) cyc++;
  always @(posedge step_out)
  begin
    n_step++;
    gap = cyc - last;
    last = cyc;
    // Let direction settle after the step edge
    #1 dir_seen = dir_out;
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // One bus access, held until waitrequest is seen low
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    k = 0;
    do @(posedge clk); while (avs_waitrequest !== 1'b0 && ++k < 50);
    got = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    chk(32'(k < 50), 1);
  endtask
  task wint(input int lim);
    int k;
    for (k = 0; k < lim && int_out !== 1'b1; k++) @(posedge clk);
    chk({31'h0, int_out}, 1);
  endtask
  task wsep();
    int k;
    for (k = 0; k < 500 && sep_on !== 1'b1; k++) @(posedge clk);
    chk({31'h0, sep_on}, 1);
  endtask
  // Shared seek run: launch, busy, steps, interval, sense, clear
  task run_seek(input logic [31:0] cmd, input int steps, input logic [15:0] sense,
    input logic dir);
    n_step = 0;
    bus(1, OFF_CMD, cmd);
    bus(0, OFF_MSR, 0);
    chk(got[0], 1);
    wint(steps * 210 + 1000);
    chk(n_step, steps);
    chk(gap, 200);
    chk(dir_seen, dir);
    bus(0, OFF_SENSE, 0);
    chk(got[15:0], sense);
    repeat (4) @(posedge clk);
    chk(int_out, 0);
    bus(0, OFF_SENSE, 0);
    chk(got[7:0], ST0_INVALID);
  endtask
  task t_regs();
    bus(0, OFF_TIMING, 0);
    chk(got, TIMING_RST);
    bus(0, 8'h30, 0);
    chk(got, 0);
    bus(1, OFF_MODE, 3);
    bus(0, OFF_MODE, 0);
    chk(got[1:0], 2'h3);
    bus(1, OFF_MODE, 0);
    bus(1, OFF_TIMING, 32'h0002_0002);
    $display("test regs done");
  endtask
  task t_recal_max();
    run_seek(32'h4, 85, 16'h0060, 0);
    $display("test recal max done");
  endtask
  task t_rel_out();
    bus(1, OFF_REL, 120);
    run_seek(32'h5, 115, 16'h8c20, 0);
    $display("test rel out done");
  endtask
  task t_rel_in();
    bus(1, OFF_REL, 3);
    run_seek(32'h205, 3, 16'h8f20, 1);
    $display("test rel in done");
  endtask
  task t_recal();
    run_seek(32'h4, 3, 16'h0020, 0);
    bus(0, OFF_PTR, 0);
    chk(got[7:0], 0);
    $display("test recal done");
  endtask
  task t_rdid();
    bus(1, OFF_CMD, 32'h2);
    chk(sep_on, 0);
    wsep();
    af_id <= 32'h0501_0302;
    af_valid <= 1'b1;
    @(posedge clk);
    af_valid <= 1'b0;
    wint(100);
    bus(0, OFF_RES0, 0);
    chk(got[7:6], IC_NORM);
    bus(0, OFF_RES1, 0);
    chk(got, 32'h0501_0302);
    $display("test read id done");
  endtask
  task t_rdid_ma();
    bus(1, OFF_CMD, 32'h2);
    wsep();
    repeat (2)
    begin
      index_pin <= 1'b1;
      repeat (4) @(posedge clk);
      index_pin <= 1'b0;
      repeat (20) @(posedge clk);
    end
    wint(100);
    bus(0, OFF_RES0, 0);
    chk(got[15:0], 16'h0140);
    bus(0, OFF_RES1, 0);
    $display("test missing mark done");
  endtask
  task t_rdid_abort();
    bus(1, OFF_CMD, 32'h2);
    wsep();
    bus(1, OFF_FIFO, 0);
    wint(100);
    bus(0, OFF_RES0, 0);
    chk(got[7:6], IC_ABN);
    bus(0, OFF_RES1, 0);
    $display("test abort done");
  endtask
  // Track read ended by a host byte before the index
  task t_trk_abort();
    bus(1, OFF_CMD, 32'h3);
    wsep();
    bus(1, OFF_FIFO, 0);
    wint(100);
    bus(0, OFF_RES0, 0);
    chk(got[7:6], IC_ABN);
    bus(0, OFF_RES1, 0);
    $display("test track abort done");
  endtask
  // Deleted read meets a normal mark: flag, read, stop
  task t_rddel();
    bus(1, OFF_PARAM, 32'h0209_0205);
    bus(1, OFF_CMD, 32'h1);
    wsep();
    af_id <= 32'h0500_0202;
    af_valid <= 1'b1;
    @(posedge clk);
    af_valid <= 1'b0;
    repeat (2) @(posedge clk);
    dm_valid <= 1'b1;
    @(posedge clk);
    dm_valid <= 1'b0;
    repeat (2) @(posedge clk);
    chk(xfer_en, 1);
    df_end <= 1'b1;
    @(posedge clk);
    df_end <= 1'b0;
    wint(100);
    bus(0, OFF_RES0, 0);
    chk(got[23:0], 24'h40_0000);
    bus(0, OFF_RES1, 0);
    chk(got, 32'h0500_0302);
    $display("test read deleted done");
  endtask
  task end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Watchdog against a hang
  initial
  begin
    #1_000_000;
    n_fail++;
    end_sim();
  end
  initial
  begin
    {rstn, avs_read, avs_write, index_pin, af_valid, dm_valid, df_end} = 0;
    {avs_address, avs_writedata, af_id} = 0;
    af_crc_ok = 1;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_recal_max();
    t_rel_out();
    t_rel_in();
    t_recal();
    t_rdid();
    t_rdid_ma();
    t_rdid_abort();
    t_trk_abort();
    t_rddel();
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
